//--- verilog/kp_pkg.sv
/*
 * kp_pkg: register indices, field layouts, reset values, timing counts
 * and carrier types shared by the keypad control/status block.
 * Assumes a 200 MHz aclk and an AXI4-Lite register bus with 32-bit data.
 */
package kp_pkg;

   // register indices; byte address is four times the index
   localparam logic [9:0] KP_IDX_COL_RESULT = 10'h0d1;
   localparam logic [9:0] KP_IDX_ROW_RESULT = 10'h0d2;
   localparam logic [9:0] KP_IDX_CTRL_STAT = 10'h0d4;
   localparam logic [9:0] KP_IDX_DIMS = 10'h0d5;
   localparam logic [9:0] KP_IDX_IRQ_STAT = 10'h0e0;
   localparam logic [9:0] KP_IDX_IRQ_MASK = 10'h0e1;
   localparam logic [9:0] KP_IDX_CLK_CTRL = 10'h0e2;

   // keypad control/status field positions
   localparam int KP_BIT_IRQ_EN = 0;
   localparam int KP_BIT_FLAG = 1;
   localparam int KP_BIT_AUTO = 2;
   localparam int KP_BIT_SCLK = 3;

   // keypad dimension fields
   localparam int KP_ROW_LSB = 3;
   localparam int KP_COL_LSB = 0;

   // geometry
   localparam int KP_NROW = 6;
   localparam int KP_NCOL = 5;

   // reset values
   localparam logic [7:0] KP_DIMS_RST = 8'h00;
   localparam logic [4:0] KP_COL_RST = 5'h1f;
   localparam logic KP_CLK_RUN_RST = 1'b1;

   // timing: scan clock of 1 kHz on a 5 ns aclk
   localparam int KP_CLK_PERIOD_NS = 5;
   localparam int KP_SCAN_PERIOD_US = 1000;
   localparam int KP_HALF_CYC = (KP_SCAN_PERIOD_US * 1000) / (2 * KP_CLK_PERIOD_NS);
   localparam int KP_DEB_TICKS = 4;

   // axi responses
   localparam logic [1:0] KP_RESP_OKAY = 2'h0;
   localparam logic [1:0] KP_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic auto_scan_enable;
      logic key_detect_irq_enable;
   } kp_ctrl_s;

   typedef struct packed {
      logic [2:0] row_count;
      logic [2:0] column_count;
   } kp_dims_s;

   typedef enum logic [1:0] {SC_IDLE, SC_STEP, SC_DEBOUNCE, SC_RELEASE} kp_scan_e;

endpackage : kp_pkg

//--- verilog/kp_tick_gen.sv
/*
 * kp_tick_gen: divides aclk down to the keypad scan clock level and a
 * one-cycle enable at each rising edge of that level.
 * Assumes run is from the aclk domain; a stopped clock freezes the level.
 */
`timescale 1ns/1ps
module kp_tick_gen #(
   parameter int unsigned HALF = 100000
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, low
   input wire logic run, // divider runs
   output logic level, // scan clock level
   output logic tick // one-cycle pulse on rise
);
   localparam int CW = $clog2(HALF + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF - 1);

   logic [CW-1:0] cnt_r, cnt_nxt;
   logic level_r, level_nxt, tick_r, tick_nxt;

   // half-period counter toggles the level
   always_comb begin
      cnt_nxt = cnt_r;
      level_nxt = level_r;
      tick_nxt = 1'b0;
      if (run) begin
         if (cnt_r == LAST) begin
            cnt_nxt = '0;
            level_nxt = ~level_r;
            tick_nxt = ~level_r;
         end else begin
            cnt_nxt = cnt_r + CW'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
         level_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         level_r <= level_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign level = level_r;
   assign tick = tick_r;

endmodule : kp_tick_gen

//--- verilog/kp_row_sense.sv
/*
 * kp_row_sense: two-flop synchroniser for the row sense pins and a
 * detector for a falling row while all rows were high before.
 * Assumes rows idle high through external pull-ups.
 */
`timescale 1ns/1ps
module kp_row_sense #(
   parameter int N = 6
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, low
   input wire logic [N-1:0] row_i, // raw row pins
   output logic [N-1:0] rows, // synchronised rows
   output logic fall // pulse: first row fell
);
   logic [N-1:0] meta_r, sync_r, prev_r;
   logic fall_r, fall_nxt;

   // only sync_r reads meta_r
   always_comb begin
      fall_nxt = (&prev_r) && !(&sync_r);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '1;
         sync_r <= '1;
         prev_r <= '1;
         fall_r <= 1'b0;
      end else begin
         meta_r <= row_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
         fall_r <= fall_nxt;
      end
   end

   assign rows = sync_r;
   assign fall = fall_r;

endmodule : kp_row_sense

//--- verilog/kp_keypad_ctrl.sv
/*
 * kp_keypad_ctrl: keypad control/status with a small column scanner,
 * AXI4-Lite register slave and one level interrupt.
 * Assumes 200 MHz aclk, rows pulled high, columns driven active low.
 */
// What this block does
// - scan clock level readable at bit 3
// - auto scan enable runs hardware scanning
// - auto scan off: firmware drives, no scanning
// - debounced hardware key sets key detect flag
// - bypass: row fall from all-high sets flag
// - reading control/status clears key detect flag
// - bypass detection works with scan clock stopped
// - irq enable bit gates the flag path of the interrupt; irq mask gates the status path
// - flag sets even with interrupt disabled
// - dimensions reset zero: rows 5:3, columns 2:0
// - scan limited to row and column counts
// - column result holds active-low detected column
`timescale 1ns/1ps
module kp_keypad_ctrl import kp_pkg::*; #(
   parameter int unsigned HALF_CYC = KP_HALF_CYC,
   parameter int DEB_TICKS = KP_DEB_TICKS
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, low
   input wire logic [11:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte enables
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [11:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic [KP_NROW-1:0] row_i, // row sense pins
   output logic [KP_NCOL-1:0] col_drive_n, // column drive, low active
   output logic irq // keypad interrupt, high
);
   localparam int DW = $clog2(DEB_TICKS + 1);

   // clamp a count field: zero or too big means all lines
   function automatic logic [2:0] kp_clamp(input logic [2:0] n, input logic [2:0] max);
      kp_clamp = (n == 3'h0 || n > max) ? max : n;
   endfunction : kp_clamp

   function automatic logic kp_hit(input logic [11:0] a, input logic [9:0] idx);
      kp_hit = (a[11:2] == idx);
   endfunction : kp_hit

   logic scan_level, scan_tick, row_fall;
   logic [KP_NROW-1:0] rows;

   kp_ctrl_s ctrl_r, ctrl_nxt;
   kp_dims_s dims_r, dims_nxt;
   logic flag_r, flag_nxt, ist_r, ist_nxt, imask_r, imask_nxt, clk_run_r, clk_run_nxt;
   logic irq_r, irq_nxt;
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [11:0] aw_addr_r, aw_addr_nxt;
   logic [7:0] w_data_r, w_data_nxt;
   logic w_lane_r, w_lane_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic do_wr, rd_take, rd_stat, key_evt, wr_col;

   kp_scan_e sc_state_r, sc_nxt;
   logic [2:0] col_idx_r, col_idx_nxt;
   logic [DW-1:0] deb_r, deb_nxt;
   logic [KP_NROW-1:0] hit_r, hit_nxt, row_res_r, row_res_nxt, rows_eff, row_mask;
   logic [KP_NCOL-1:0] col_res_r, col_res_nxt, drive_r, drive_nxt;
   logic scan_det;

   // divider runs from its own enable, so stopping it never touches rows
   kp_tick_gen #(.HALF(HALF_CYC)) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(clk_run_r),
      .level(scan_level),
      .tick(scan_tick)
   );

   kp_row_sense #(.N(KP_NROW)) u_rows (
      .aclk(aclk),
      .aresetn(aresetn),
      .row_i(row_i),
      .rows(rows),
      .fall(row_fall)
   );

   // scanner: step columns each tick, debounce a hit, wait for release
   always_comb begin
      logic [2:0] ncol;
      logic [2:0] nrow;
      ncol = kp_clamp(dims_r.column_count, 3'(KP_NCOL));
      nrow = kp_clamp(dims_r.row_count, 3'(KP_NROW));
      for (int i = 0; i < KP_NROW; i++) begin
         row_mask[i] = (i < int'(nrow));
      end
      rows_eff = rows | ~row_mask;
      sc_nxt = sc_state_r;
      col_idx_nxt = col_idx_r;
      deb_nxt = deb_r;
      hit_nxt = hit_r;
      row_res_nxt = row_res_r;
      col_res_nxt = col_res_r;
      scan_det = 1'b0;
      // a shrunk column count must not leave the index on a dead column
      if (col_idx_r >= ncol) begin
         col_idx_nxt = 3'h0;
      end
      if (!ctrl_r.auto_scan_enable) begin
         sc_nxt = SC_IDLE;
         col_idx_nxt = 3'h0;
      end else if (sc_state_r == SC_IDLE) begin
         sc_nxt = SC_STEP;
      end else if (scan_tick) begin
         unique case (sc_state_r)
            SC_STEP: begin
               if (!(&rows_eff)) begin
                  hit_nxt = rows_eff;
                  deb_nxt = '0;
                  sc_nxt = SC_DEBOUNCE;
               end else begin
                  col_idx_nxt = (col_idx_r + 3'h1 >= ncol) ? 3'h0 : col_idx_r + 3'h1;
               end
            end
            SC_DEBOUNCE: begin
               if (rows_eff != hit_r) begin
                  sc_nxt = SC_STEP;
               end else if (deb_r == DW'(DEB_TICKS - 1)) begin
                  scan_det = 1'b1;
                  row_res_nxt = hit_r;
                  col_res_nxt = drive_r;
                  sc_nxt = SC_RELEASE;
               end else begin
                  deb_nxt = deb_r + DW'(1);
               end
            end
            SC_RELEASE: begin
               if (&rows_eff) begin
                  sc_nxt = SC_STEP;
                  col_idx_nxt = (col_idx_r + 3'h1 >= ncol) ? 3'h0 : col_idx_r + 3'h1;
               end
            end
            SC_IDLE: sc_nxt = SC_STEP;
         endcase
      end
      if (wr_col && !ctrl_r.auto_scan_enable) begin
         col_res_nxt = w_data_r[KP_NCOL-1:0];
      end
      drive_nxt = ctrl_r.auto_scan_enable ? ~(KP_NCOL'(1) << col_idx_nxt) : col_res_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sc_state_r <= SC_IDLE;
         col_idx_r <= 3'h0;
         deb_r <= '0;
         hit_r <= '1;
         row_res_r <= '1;
         col_res_r <= KP_COL_RST;
         drive_r <= KP_COL_RST;
      end else begin
         sc_state_r <= sc_nxt;
         col_idx_r <= col_idx_nxt;
         deb_r <= deb_nxt;
         hit_r <= hit_nxt;
         row_res_r <= row_res_nxt;
         col_res_r <= col_res_nxt;
         drive_r <= drive_nxt;
      end
   end

   // bus slave and status; a key event in the clearing cycle wins
   always_comb begin
      logic [11:0] wa;
      logic rd_ok;
      logic [7:0] rv;
      wa = aw_addr_r;
      rd_ok = 1'b1;
      rv = 8'h00;
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt = w_data_r;
      w_lane_nxt = w_lane_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      ctrl_nxt = ctrl_r;
      dims_nxt = dims_r;
      imask_nxt = imask_r;
      clk_run_nxt = clk_run_r;
      if (awvalid && awready_r) begin
         aw_have_nxt = 1'b1;
         aw_addr_nxt = awaddr;
      end
      if (wvalid && wready_r) begin
         w_have_nxt = 1'b1;
         w_data_nxt = wdata[7:0];
         w_lane_nxt = wstrb[0];
      end
      if (bvalid_r && bready) begin
         bvalid_nxt = 1'b0;
      end
      do_wr = aw_have_r && w_have_r && !bvalid_r;
      wr_col = do_wr && w_lane_r && kp_hit(wa, KP_IDX_COL_RESULT);
      if (do_wr) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = KP_RESP_OKAY;
         if (kp_hit(wa, KP_IDX_CTRL_STAT)) begin
            if (w_lane_r) begin
               ctrl_nxt.auto_scan_enable = w_data_r[KP_BIT_AUTO];
               ctrl_nxt.key_detect_irq_enable = w_data_r[KP_BIT_IRQ_EN];
            end
         end else if (kp_hit(wa, KP_IDX_DIMS)) begin
            if (w_lane_r) begin
               dims_nxt = w_data_r[5:0];
            end
         end else if (kp_hit(wa, KP_IDX_IRQ_MASK)) begin
            if (w_lane_r) begin
               imask_nxt = w_data_r[0];
            end
         end else if (kp_hit(wa, KP_IDX_CLK_CTRL)) begin
            if (w_lane_r) begin
               clk_run_nxt = w_data_r[0];
            end
         end else if (!kp_hit(wa, KP_IDX_COL_RESULT) && !kp_hit(wa, KP_IDX_IRQ_STAT)) begin
            bresp_nxt = KP_RESP_SLVERR;
         end
      end
      if (rvalid_r && rready) begin
         rvalid_nxt = 1'b0;
      end
      rd_take = arvalid && arready_r;
      rd_stat = rd_take && kp_hit(araddr, KP_IDX_CTRL_STAT);
      if (kp_hit(araddr, KP_IDX_CTRL_STAT)) begin
         rv = {4'h0, scan_level, ctrl_r.auto_scan_enable, flag_r, ctrl_r.key_detect_irq_enable};
      end else if (kp_hit(araddr, KP_IDX_DIMS)) begin
         rv = {2'h0, dims_r};
      end else if (kp_hit(araddr, KP_IDX_COL_RESULT)) begin
         rv = {3'h0, col_res_r};
      end else if (kp_hit(araddr, KP_IDX_ROW_RESULT)) begin
         rv = {2'h0, ctrl_r.auto_scan_enable ? row_res_r : rows};
      end else if (kp_hit(araddr, KP_IDX_IRQ_STAT)) begin
         rv = {7'h00, ist_r};
      end else if (kp_hit(araddr, KP_IDX_IRQ_MASK)) begin
         rv = {7'h00, imask_r};
      end else if (kp_hit(araddr, KP_IDX_CLK_CTRL)) begin
         rv = {7'h00, clk_run_r};
      end else begin
         rd_ok = 1'b0;
      end
      if (rd_take) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = {24'h000000, rv};
         rresp_nxt = rd_ok ? KP_RESP_OKAY : KP_RESP_SLVERR;
      end
      // bypass edge uses aclk only, never the scan clock
      key_evt = ctrl_r.auto_scan_enable ? scan_det : row_fall;
      flag_nxt = key_evt || (flag_r && !rd_stat);
      ist_nxt = key_evt || (ist_r && !(do_wr && w_lane_r && kp_hit(wa, KP_IDX_IRQ_STAT)
                                      && w_data_r[0]));
      irq_nxt = (flag_nxt && ctrl_nxt.key_detect_irq_enable) || (ist_nxt && imask_nxt);
      awready_nxt = !aw_have_nxt && !bvalid_nxt;
      wready_nxt = !w_have_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= '0;
         dims_r <= KP_DIMS_RST[5:0];
         flag_r <= 1'b0;
         ist_r <= 1'b0;
         imask_r <= 1'b0;
         clk_run_r <= KP_CLK_RUN_RST;
         irq_r <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_data_r <= 8'h00;
         w_lane_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         arready_r <= 1'b0;
         bvalid_r <= 1'b0;
         rvalid_r <= 1'b0;
         bresp_r <= KP_RESP_OKAY;
         rresp_r <= KP_RESP_OKAY;
         rdata_r <= 32'h00000000;
      end else begin
         ctrl_r <= ctrl_nxt;
         dims_r <= dims_nxt;
         flag_r <= flag_nxt;
         ist_r <= ist_nxt;
         imask_r <= imask_nxt;
         clk_run_r <= clk_run_nxt;
         irq_r <= irq_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r <= w_data_nxt;
         w_lane_r <= w_lane_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         arready_r <= arready_nxt;
         bvalid_r <= bvalid_nxt;
         rvalid_r <= rvalid_nxt;
         bresp_r <= bresp_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign col_drive_n = drive_r;
   assign irq = irq_r;

   // checks
   sequence bypass_fall_s;
      !ctrl_r.auto_scan_enable && row_fall;
   endsequence

   sequence stat_read_s;
      rd_stat && !key_evt;
   endsequence

   scan_level_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_stat |=> rdata_r[KP_BIT_SCLK] == $past(scan_level))
      else $error("scan clock level not reported");
   bypass_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_r.auto_scan_enable && !$past(ctrl_r.auto_scan_enable)
      && !$past(ctrl_r.auto_scan_enable, 2) && !$past(wr_col)
      |-> $stable(col_drive_n) && sc_state_r == SC_IDLE)
      else $error("columns moved in bypass");
   hw_detect_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_r.auto_scan_enable && scan_det |=> flag_r && sc_state_r == SC_RELEASE)
      else $error("hardware detect did not set flag");
   bypass_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      bypass_fall_s |=> flag_r)
      else $error("row fall did not set flag");
   read_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      stat_read_s |=> !flag_r)
      else $error("status read did not clear flag");
   edge_no_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
      bypass_fall_s ##0 !clk_run_r ##0 ctrl_nxt.key_detect_irq_enable |=> irq_r)
      else $error("stopped clock blocked detection");
   irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_r.key_detect_irq_enable && !(ist_r && imask_r) |-> !irq_r)
      else $error("interrupt without enable");
   poll_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      key_evt && !ctrl_r.key_detect_irq_enable |=> flag_r)
      else $error("flag lost with irq disabled");
   dims_reset_a: assert property (@(posedge aclk)
      !$past(aresetn) |-> dims_r == KP_DIMS_RST[5:0])
      else $error("dimensions not zero after reset");
   col_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $stable(dims_r) |-> col_idx_r < kp_clamp(dims_r.column_count, 3'(KP_NCOL)))
      else $error("scan beyond column count");
   col_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_det |=> col_res_r == $past(drive_r) && !(&col_res_r))
      else $error("column result wrong");
   irq_and_a: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_r == ((flag_r && ctrl_r.key_detect_irq_enable) || (ist_r && imask_r)))
      else $error("irq not flag and enable");

endmodule : kp_keypad_ctrl

//--- testbench/kp_keypad_model.sv
/*
 * kp_keypad_model: one switch of a row/column keypad matrix.
 * Assumes columns are driven active low and rows have pull-ups.
 */
`timescale 1ns/1ps
module kp_keypad_model (
   input wire logic [4:0] col_drive_n, // column drive, low active
   input wire logic press, // key held down
   input wire logic [2:0] key_row, // row of the key
   input wire logic [2:0] key_col, // column of the key
   output logic [5:0] row_i // row sense lines
);
   // released rows float up to the pull-up level, never the last value
   always_comb begin
      row_i = 6'h3f;
      if (press && !col_drive_n[key_col]) begin
         row_i[key_row] = 1'b0;
      end
   end
endmodule : kp_keypad_model

//--- testbench/tb.sv
/*
 * tb: self-checking bench for the keypad control/status block.
 * Assumes the keypad model on the row/column pins and a shortened scan clock.
 */
`timescale 1ns/1ps
module tb import kp_pkg::*;;
   typedef struct packed {
      logic wr;
      logic [9:0] ix;
      logic [7:0] d;
      logic [7:0] m;
      logic [7:0] e;
      logic [1:0] r;
   } kp_row_s;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq, press;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [5:0] row_i;
   logic [4:0] col_drive_n;
   logic [2:0] row_result, column_result;
   int err_total, checks;
   // ordinary register cases: access, index, data, mask, expected, response
   kp_row_s tbl [14] = '{
      '{1'b0, KP_IDX_DIMS, 8'h00, 8'hff, 8'h00, KP_RESP_OKAY},
      '{1'b0, KP_IDX_CTRL_STAT, 8'h00, 8'h07, 8'h00, KP_RESP_OKAY},
      '{1'b0, KP_IDX_COL_RESULT, 8'h00, 8'hff, 8'h1f, KP_RESP_OKAY},
      '{1'b0, KP_IDX_CLK_CTRL, 8'h00, 8'h01, 8'h01, KP_RESP_OKAY},
      '{1'b1, KP_IDX_DIMS, 8'hff, 8'h00, 8'h00, KP_RESP_OKAY},
      '{1'b0, KP_IDX_DIMS, 8'h00, 8'hff, 8'h3f, KP_RESP_OKAY},
      '{1'b1, KP_IDX_DIMS, 8'h2d, 8'h00, 8'h00, KP_RESP_OKAY},
      '{1'b0, KP_IDX_DIMS, 8'h00, 8'hff, 8'h2d, KP_RESP_OKAY},
      '{1'b0, 10'h0ff, 8'h00, 8'h00, 8'h00, KP_RESP_SLVERR},
      '{1'b1, 10'h0ff, 8'h00, 8'h00, 8'h00, KP_RESP_SLVERR},
      '{1'b1, KP_IDX_CTRL_STAT, 8'h0e, 8'h00, 8'h00, KP_RESP_OKAY},
      '{1'b0, KP_IDX_CTRL_STAT, 8'h00, 8'h07, 8'h04, KP_RESP_OKAY},
      '{1'b1, KP_IDX_CTRL_STAT, 8'h00, 8'h00, 8'h00, KP_RESP_OKAY},
      '{1'b1, KP_IDX_DIMS, 8'h00, 8'h00, 8'h00, KP_RESP_OKAY}};

   kp_keypad_ctrl #(.HALF_CYC(4), .DEB_TICKS(2)) DUT (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .row_i(row_i), .col_drive_n(col_drive_n), .irq(irq));
   kp_keypad_model pad (.col_drive_n(col_drive_n), .press(press), .key_row(row_result),
      .key_col(column_result), .row_i(row_i));

   // 200 MHz system clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [9:0] ix, input logic [7:0] d, output logic [1:0] r);
      int n;
      logic ad, wd, done;
      ad = 0;
      wd = 0;
      n = 0;
      @(posedge aclk);
      awaddr <= {ix, 2'b00};
      awvalid <= 1'b1;
      wdata <= {24'h0, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         done = ad && wd && bvalid;
         if (awready && !ad) begin
            awvalid <= 1'b0;
            ad = 1;
         end
         if (wready && !wd) begin
            wvalid <= 1'b0;
            wd = 1;
         end
      end while (!done && n < 300);
      if (!done) err_total++;
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [9:0] ix, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ad, done;
      ad = 0;
      n = 0;
      @(posedge aclk);
      araddr <= {ix, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         done = ad && rvalid;
         if (arready && !ad) begin
            arvalid <= 1'b0;
            ad = 1;
         end
      end while (!done && n < 300);
      if (!done) err_total++;
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   // bounded wait for the interrupt line
   task automatic wt(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge aclk);
         n++;
      end
   endtask : wt

   // watchdog: the whole run needs well under 20000 cycles
   initial begin
      #100000;
      err_total++;
      wrap_up();
   end

   initial begin
      logic [31:0] d;
      logic [1:0] rs;
      logic s0, s1;
      {aresetn, awvalid, wvalid, bready, arvalid, rready, press} = '0;
      {awaddr, araddr, wdata, row_result, column_result} = '0;
      wstrb = 4'h1;
      err_total = 0;
      checks = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("irq_rst", irq, 0);
      foreach (tbl[i]) begin
         if (tbl[i].wr) wr(tbl[i].ix, tbl[i].d, rs);
         else begin
            rd(tbl[i].ix, d, rs);
            chk("reg", d & tbl[i].m, tbl[i].e);
         end
         chk("resp", rs, tbl[i].r);
      end
      // bypass: columns all low, a key pulls a row down
      wr(KP_IDX_IRQ_MASK, 8'h00, rs);
      wr(KP_IDX_CTRL_STAT, 8'h01, rs);
      wr(KP_IDX_COL_RESULT, 8'h00, rs);
      row_result <= 3'd2;
      column_result <= 3'd1;
      press <= 1'b1;
      wt(20);
      chk("irq_byp", irq, 1);
      rd(KP_IDX_CTRL_STAT, d, rs);
      chk("flag_set", d[1], 1);
      repeat (2) @(posedge aclk);
      chk("irq_clr", irq, 0);
      rd(KP_IDX_CTRL_STAT, d, rs);
      chk("flag_clr", d[1], 0);
      press <= 1'b0;
      repeat (10) @(posedge aclk);
      // interrupt disabled: flag still sets, sticky status and mask
      wr(KP_IDX_CTRL_STAT, 8'h00, rs);
      press <= 1'b1;
      repeat (20) @(posedge aclk);
      chk("irq_off", irq, 0);
      rd(KP_IDX_CTRL_STAT, d, rs);
      chk("flag_poll", d[1], 1);
      rd(KP_IDX_IRQ_STAT, d, rs);
      chk("stat", d[0], 1);
      wr(KP_IDX_IRQ_MASK, 8'h01, rs);
      repeat (2) @(posedge aclk);
      chk("irq_mask", irq, 1);
      wr(KP_IDX_IRQ_STAT, 8'h01, rs);
      repeat (2) @(posedge aclk);
      chk("irq_w1c", irq, 0);
      wr(KP_IDX_IRQ_MASK, 8'h00, rs);
      press <= 1'b0;
      repeat (10) @(posedge aclk);
      // scan clock level must be seen both ways while running
      s0 = 1;
      s1 = 0;
      repeat (8) begin
         rd(KP_IDX_CTRL_STAT, d, rs);
         s0 &= d[3];
         s1 |= d[3];
      end
      chk("sclk_lo", s0, 0);
      chk("sclk_hi", s1, 1);
      // scan clock stopped: level frozen, bypass edge still detected
      wr(KP_IDX_CLK_CTRL, 8'h00, rs);
      rd(KP_IDX_CTRL_STAT, d, rs);
      s0 = d[3];
      repeat (20) @(posedge aclk);
      rd(KP_IDX_CTRL_STAT, d, rs);
      chk("sclk_stop", d[3], s0);
      wr(KP_IDX_CTRL_STAT, 8'h01, rs);
      press <= 1'b1;
      wt(20);
      chk("irq_noclk", irq, 1);
      rd(KP_IDX_CTRL_STAT, d, rs);
      press <= 1'b0;
      wr(KP_IDX_CLK_CTRL, 8'h01, rs);
      // bypass columns hold the written pattern, no scanning
      wr(KP_IDX_COL_RESULT, 8'h1e, rs);
      repeat (60) @(posedge aclk);
      chk("col_byp", col_drive_n, 5'h1e);
      // hardware scan finds row 3, column 2
      wr(KP_IDX_CTRL_STAT, 8'h05, rs);
      row_result <= 3'd3;
      column_result <= 3'd2;
      press <= 1'b1;
      wt(800);
      chk("irq_auto", irq, 1);
      rd(KP_IDX_COL_RESULT, d, rs);
      chk("col_res", d, 32'h1b);
      rd(KP_IDX_ROW_RESULT, d, rs);
      chk("row_res", d, 32'h37);
      rd(KP_IDX_CTRL_STAT, d, rs);
      chk("flag_auto", d[1], 1);
      press <= 1'b0;
      repeat (200) @(posedge aclk);
      rd(KP_IDX_CTRL_STAT, d, rs);
      // two columns only: a key beyond them is never found
      wr(KP_IDX_DIMS, 8'h32, rs);
      column_result <= 3'd3;
      press <= 1'b1;
      repeat (600) @(posedge aclk);
      chk("irq_lim", irq, 0);
      press <= 1'b0;
      repeat (100) @(posedge aclk);
      column_result <= 3'd1;
      press <= 1'b1;
      wt(800);
      chk("irq_in", irq, 1);
      wrap_up();
   end
endmodule : tb
